// ===== common/prcg_pkg.sv
// constants shared by the peripheral reset and clock gate block
package prcg_pkg;
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;
    localparam int STRB_W   = 4;
    localparam int PRD_SEL_W = 6;

    localparam logic [7:0] LS_RST_OFF = 8'h10;
    localparam logic [7:0] SYS_EN_OFF = 8'h14;
    localparam logic [7:0] HS_EN_OFF  = 8'h18;

    localparam logic [31:0] LS_RST_RESET = 32'h00000000;
    localparam logic [31:0] SYS_EN_RESET = 32'h00000014;
    localparam logic [31:0] HS_EN_RESET  = 32'h00000000;

    // writable bits; everything else reads zero
    localparam logic [31:0] LS_RST_MASK = 32'h3afec83f;
    localparam logic [31:0] SYS_EN_MASK = 32'h00000557;
    localparam logic [31:0] HS_EN_MASK  = 32'h0000fffd;

    localparam logic [1:0] REG_LS   = 2'h0;
    localparam logic [1:0] REG_SYS  = 2'h1;
    localparam logic [1:0] REG_HS   = 2'h2;
    localparam logic [1:0] REG_NONE = 2'h3;

    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    // low-speed reset register
    localparam int CONVERTER_IF_RESET_BIT    = 29;
    localparam int POWER_IF_RESET_BIT        = 28;
    localparam int BACKUP_IF_RESET_BIT       = 27;
    localparam int CAN_CTRL_RESET_BIT        = 25;
    localparam int USB_CTRL_RESET_BIT        = 23;
    localparam int SECOND_I2C_RESET_BIT      = 22;
    localparam int FIRST_I2C_RESET_BIT       = 21;
    localparam int SERIAL5_RESET_BIT         = 20;
    localparam int SERIAL2_RESET_BIT         = 17;
    localparam int THIRD_SPI_RESET_BIT       = 15;
    localparam int SECOND_SPI_RESET_BIT      = 14;
    localparam int WINDOW_WATCHDOG_RESET_BIT = 11;
    localparam int TIMER7_RESET_BIT          = 5;
    localparam int TIMER2_RESET_BIT          = 0;

    // system-bus clock enable register
    localparam int SD_HOST_CLOCK_ON         = 10;
    localparam int STATIC_MEM_CTRL_CLOCK_ON = 8;
    localparam int CHECKSUM_UNIT_CLOCK_ON   = 6;
    localparam int FLASH_IF_SLEEP_CLOCK_ON  = 4;
    localparam int SRAM_SLEEP_CLOCK_ON      = 2;
    localparam int SECOND_DMA_CLOCK_ON      = 1;
    localparam int FIRST_DMA_CLOCK_ON       = 0;

    // high-speed-bus clock enable register
    localparam int CONVERTER3_CLOCK_ON       = 15;
    localparam int SERIAL1_CLOCK_ON          = 14;
    localparam int ADVANCED_TIMER8_CLOCK_ON  = 13;
    localparam int FIRST_SPI_CLOCK_ON        = 12;
    localparam int ADVANCED_TIMER1_CLOCK_ON  = 11;
    localparam int CONVERTER2_CLOCK_ON       = 10;
    localparam int CONVERTER1_CLOCK_ON       = 9;
    localparam int PORT_G_CLOCK_ON           = 8;
    localparam int PORT_A_CLOCK_ON           = 2;
    localparam int ALT_FUNCTION_IO_CLOCK_ON  = 0;

    localparam int GATE_W = 16;
endpackage

// ===== core/prcg_clock_gate.sv
// glitch-free clock gate, enable taken on the falling edge
`timescale 1ns/1ns
module prcg_clock_gate (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic enable,
    output logic      gated_clk
);
    typedef struct packed {
        logic en;
    } prcg_gate_state_t;

    prcg_gate_state_t s_q;
    prcg_gate_state_t s_d;

    always_comb begin
        s_d    = s_q;
        s_d.en = aresetn & enable;
    end

    // enable only moves while aclk is low, so no runt pulse
    always_ff @(negedge aclk) begin
        s_q <= s_d;
    end

    assign gated_clk = aclk & s_q.en;
endmodule

// ===== core/prcg_top.sv
// peripheral reset and clock gate registers with AXI4-Lite slave
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ns
module prcg_top
    import prcg_pkg::*;
(
    input  wire logic                           aclk,
    input  wire logic                           aresetn,
    input  wire logic                           awvalid,
    output logic                                awready,
    input  wire logic [prcg_pkg::ADDR_W-1:0]    awaddr,
    input  wire logic                           wvalid,
    output logic                                wready,
    input  wire logic [prcg_pkg::DATA_W-1:0]    wdata,
    input  wire logic [prcg_pkg::STRB_W-1:0]    wstrb,
    output logic                                bvalid,
    input  wire logic                           bready,
    output logic [1:0]                          bresp,
    input  wire logic                           arvalid,
    output logic                                arready,
    input  wire logic [prcg_pkg::ADDR_W-1:0]    araddr,
    output logic                                rvalid,
    input  wire logic                           rready,
    output logic [prcg_pkg::DATA_W-1:0]         rdata,
    output logic [1:0]                          rresp,
    input  wire logic                           sleep_mode,
    input  wire logic                           hsbus_busy,
    input  wire logic [prcg_pkg::PRD_SEL_W-1:0] periph_rd_sel,
    input  wire logic [prcg_pkg::DATA_W-1:0]    periph_rdata_in,
    output logic [prcg_pkg::DATA_W-1:0]         periph_rdata_out,
    output logic                                converter_if_rst_n,
    output logic                                power_if_rst_n,
    output logic                                backup_if_rst_n,
    output logic                                can_ctrl_rst_n,
    output logic                                usb_ctrl_rst_n,
    output logic                                second_i2c_rst_n,
    output logic                                first_i2c_rst_n,
    output logic [3:0]                          serial5to2_rst_n,
    output logic                                third_spi_rst_n,
    output logic                                second_spi_rst_n,
    output logic                                window_watchdog_rst_n,
    output logic [5:0]                          timer7to2_rst_n,
    output logic                                sd_host_clk,
    output logic                                static_mem_ctrl_clk,
    output logic                                checksum_unit_clk,
    output logic                                flash_if_clk,
    output logic                                sram_if_clk,
    output logic                                second_dma_clk,
    output logic                                first_dma_clk,
    output logic                                converter3_clk,
    output logic                                serial1_clk,
    output logic                                advanced_timer8_clk,
    output logic                                first_spi_clk,
    output logic                                advanced_timer1_clk,
    output logic                                converter2_clk,
    output logic                                converter1_clk,
    output logic [6:0]                          port_g_to_a_clk,
    output logic                                alt_function_io_clk
);
    import prcg_pkg::*;

    typedef struct packed {
        logic [31:0]       lsrst;
        logic [31:0]       sysen;
        logic [31:0]       hsen;
        logic              aw_full;
        logic [ADDR_W-1:0] awaddr;
        logic              w_full;
        logic [DATA_W-1:0] wdata;
        logic [STRB_W-1:0] wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              ar_full;
        logic [ADDR_W-1:0] araddr;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
        logic [DATA_W-1:0] prdata;
    } prcg_state_t;

    prcg_state_t s_q;
    prcg_state_t s_d;

    function automatic logic [1:0] reg_index(
        input logic [ADDR_W-1:0] addr
    );
        logic [1:0] idx;
        idx = REG_NONE;
        if (addr[ADDR_W-1:2] == LS_RST_OFF[ADDR_W-1:2]) begin
            idx = REG_LS;
        end else if (addr[ADDR_W-1:2] == SYS_EN_OFF[ADDR_W-1:2]) begin
            idx = REG_SYS;
        end else if (addr[ADDR_W-1:2] == HS_EN_OFF[ADDR_W-1:2]) begin
            idx = REG_HS;
        end
        return idx;
    endfunction

    // merge only the addressed byte lanes, reserved bits stay zero
    function automatic logic [31:0] apply_strobe(
        input logic [31:0]       old_v,
        input logic [31:0]       new_v,
        input logic [STRB_W-1:0] strb,
        input logic [31:0]       mask
    );
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < STRB_W; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res & mask;
    endfunction

    logic [1:0]  wr_idx;
    logic [1:0]  rd_idx;
    logic        wr_go;
    logic        rd_go;
    logic [31:0] sys_on;
    logic [31:0] hs_on;
    logic [63:0] all_on;
    logic [31:0] ls_rst_n;
    logic [31:0] ls_expect;
    logic [GATE_W-1:0] sys_gclk;
    logic [GATE_W-1:0] hs_gclk;

    assign wr_idx = reg_index(s_q.awaddr);
    assign rd_idx = reg_index(s_q.araddr);

    // a high-speed-bus peripheral access in flight stretches the answer for the high-speed-bus enable register
    assign wr_go = s_q.aw_full && s_q.w_full && !s_q.bvalid
                   && !(wr_idx == REG_HS && hsbus_busy);
    assign rd_go = s_q.ar_full && !s_q.rvalid
                   && !(rd_idx == REG_HS && hsbus_busy);

    assign ls_expect = apply_strobe(s_q.lsrst, s_q.wdata, s_q.wstrb,
                                    LS_RST_MASK);

    // flash and SRAM run normally; their bits matter only in sleep
    always_comb begin
        sys_on = s_q.sysen & SYS_EN_MASK;
        sys_on[FLASH_IF_SLEEP_CLOCK_ON] =
            !sleep_mode || s_q.sysen[FLASH_IF_SLEEP_CLOCK_ON];
        sys_on[SRAM_SLEEP_CLOCK_ON] =
            !sleep_mode || s_q.sysen[SRAM_SLEEP_CLOCK_ON];
    end

    assign hs_on  = s_q.hsen & HS_EN_MASK;
    assign all_on = {hs_on, sys_on};

    always_comb begin
        s_d = s_q;
        if (s_q.bvalid && bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.rvalid && rready) begin
            s_d.rvalid = 1'b0;
        end
        if (awvalid && awready) begin
            s_d.aw_full = 1'b1;
            s_d.awaddr  = awaddr;
        end
        if (wvalid && wready) begin
            s_d.w_full = 1'b1;
            s_d.wdata  = wdata;
            s_d.wstrb  = wstrb;
        end
        if (wr_go) begin
            s_d.aw_full = 1'b0;
            s_d.w_full  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = AXI_OKAY;
            unique case (wr_idx)
                REG_LS: begin
                    s_d.lsrst = ls_expect;
                end
                REG_SYS: begin
                    s_d.sysen = apply_strobe(s_q.sysen, s_q.wdata,
                                             s_q.wstrb, SYS_EN_MASK);
                end
                REG_HS: begin
                    s_d.hsen = apply_strobe(s_q.hsen, s_q.wdata,
                                            s_q.wstrb, HS_EN_MASK);
                end
                REG_NONE: begin
                    s_d.bresp = AXI_SLVERR;
                end
            endcase
        end
        if (arvalid && arready) begin
            s_d.ar_full = 1'b1;
            s_d.araddr  = araddr;
        end
        if (rd_go) begin
            s_d.ar_full = 1'b0;
            s_d.rvalid  = 1'b1;
            s_d.rresp   = AXI_OKAY;
            unique case (rd_idx)
                REG_LS:  s_d.rdata = s_q.lsrst & LS_RST_MASK;
                REG_SYS: s_d.rdata = s_q.sysen & SYS_EN_MASK;
                REG_HS:  s_d.rdata = s_q.hsen & HS_EN_MASK;
                REG_NONE: begin
                    s_d.rdata = '0;
                    s_d.rresp = AXI_SLVERR;
                end
            endcase
        end
        // a peripheral with its clock off cannot answer; hide stale data
        s_d.prdata = all_on[periph_rd_sel] ? periph_rdata_in : '0;
        if (!aresetn) begin
            s_d       = '0;
            s_d.lsrst = LS_RST_RESET;
            s_d.sysen = SYS_EN_RESET;
            s_d.hsen  = HS_EN_RESET;
        end
    end

    always_ff @(posedge aclk) begin
        s_q <= s_d;
    end

    // one write and one read in flight at a time
    assign awready = !s_q.aw_full && !s_q.bvalid;
    assign wready  = !s_q.w_full && !s_q.bvalid;
    assign bvalid  = s_q.bvalid;
    assign bresp   = s_q.bresp;
    assign arready = !s_q.ar_full && !s_q.rvalid;
    assign rvalid  = s_q.rvalid;
    assign rdata   = s_q.rdata;
    assign rresp   = s_q.rresp;
    assign periph_rdata_out = s_q.prdata;

    // software reset adds to, never replaces, the system reset
    assign ls_rst_n = {32{aresetn}} & ~s_q.lsrst;

    assign converter_if_rst_n    = ls_rst_n[CONVERTER_IF_RESET_BIT];
    assign power_if_rst_n        = ls_rst_n[POWER_IF_RESET_BIT];
    assign backup_if_rst_n       = ls_rst_n[BACKUP_IF_RESET_BIT];
    assign can_ctrl_rst_n        = ls_rst_n[CAN_CTRL_RESET_BIT];
    assign usb_ctrl_rst_n        = ls_rst_n[USB_CTRL_RESET_BIT];
    assign second_i2c_rst_n      = ls_rst_n[SECOND_I2C_RESET_BIT];
    assign first_i2c_rst_n       = ls_rst_n[FIRST_I2C_RESET_BIT];
    assign serial5to2_rst_n      =
        ls_rst_n[SERIAL5_RESET_BIT:SERIAL2_RESET_BIT];
    assign third_spi_rst_n       = ls_rst_n[THIRD_SPI_RESET_BIT];
    assign second_spi_rst_n      = ls_rst_n[SECOND_SPI_RESET_BIT];
    assign window_watchdog_rst_n = ls_rst_n[WINDOW_WATCHDOG_RESET_BIT];
    assign timer7to2_rst_n       =
        ls_rst_n[TIMER7_RESET_BIT:TIMER2_RESET_BIT];

    // one gate per writable enable; reserved positions stay low
    for (genvar i = 0; i < GATE_W; i++) begin : g_gate
        if (SYS_EN_MASK[i]) begin : g_sys
            prcg_clock_gate u_sys (
                .aclk      (aclk),
                .aresetn   (aresetn),
                .enable    (sys_on[i]),
                .gated_clk (sys_gclk[i])
            );
        end else begin : g_sys_off
            assign sys_gclk[i] = 1'b0;
        end
        if (HS_EN_MASK[i]) begin : g_hs
            prcg_clock_gate u_hs (
                .aclk      (aclk),
                .aresetn   (aresetn),
                .enable    (hs_on[i]),
                .gated_clk (hs_gclk[i])
            );
        end else begin : g_hs_off
            assign hs_gclk[i] = 1'b0;
        end
    end

    assign sd_host_clk         = sys_gclk[SD_HOST_CLOCK_ON];
    assign static_mem_ctrl_clk = sys_gclk[STATIC_MEM_CTRL_CLOCK_ON];
    assign checksum_unit_clk   = sys_gclk[CHECKSUM_UNIT_CLOCK_ON];
    assign flash_if_clk        = sys_gclk[FLASH_IF_SLEEP_CLOCK_ON];
    assign sram_if_clk         = sys_gclk[SRAM_SLEEP_CLOCK_ON];
    assign second_dma_clk      = sys_gclk[SECOND_DMA_CLOCK_ON];
    assign first_dma_clk       = sys_gclk[FIRST_DMA_CLOCK_ON];
    assign converter3_clk      = hs_gclk[CONVERTER3_CLOCK_ON];
    assign serial1_clk         = hs_gclk[SERIAL1_CLOCK_ON];
    assign advanced_timer8_clk = hs_gclk[ADVANCED_TIMER8_CLOCK_ON];
    assign first_spi_clk       = hs_gclk[FIRST_SPI_CLOCK_ON];
    assign advanced_timer1_clk = hs_gclk[ADVANCED_TIMER1_CLOCK_ON];
    assign converter2_clk      = hs_gclk[CONVERTER2_CLOCK_ON];
    assign converter1_clk      = hs_gclk[CONVERTER1_CLOCK_ON];
    assign port_g_to_a_clk     = hs_gclk[PORT_G_CLOCK_ON:PORT_A_CLOCK_ON];
    assign alt_function_io_clk = hs_gclk[ALT_FUNCTION_IO_CLOCK_ON];

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    reset_values_a:
        assert property ($rose(aresetn) |-> s_q.lsrst == LS_RST_RESET
                         && s_q.sysen == SYS_EN_RESET
                         && s_q.hsen == HS_EN_RESET)
        else $error("registers not at reset value after reset");

    ls_reserved_a:
        assert property ((s_q.lsrst & ~LS_RST_MASK) == 32'h0
                         && (!rvalid || rd_idx != REG_LS
                             || (rdata & ~LS_RST_MASK) == 32'h0))
        else $error("reserved reset bit is set");

    en_reserved_a:
        assert property ((s_q.sysen & ~SYS_EN_MASK) == 32'h0
                         && (s_q.hsen & ~HS_EN_MASK) == 32'h0)
        else $error("reserved enable bit is set");

    strobe_write_a:
        assert property (wr_go && wr_idx == REG_LS
                         |=> s_q.lsrst == $past(ls_expect)
                         && bvalid)
        else $error("reset register write ignores byte strobes");

    no_wait_a:
        assert property ((awvalid && awready && wvalid && wready
                          && reg_index(awaddr) != REG_HS)
                         |-> ##2 bvalid)
        else $error("write answer took wait states");

    hs_stall_a:
        assert property (wr_go == 1'b0 && s_q.aw_full && s_q.w_full
                         && wr_idx == REG_HS && hsbus_busy && !bvalid
                         |=> !bvalid)
        else $error("answer given while peripheral access busy");

    read_hold_a:
        assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer dropped before rready");

    reset_hold_a:
        assert property ((s_q.lsrst & ls_rst_n) == 32'h0)
        else $error("peripheral released while its reset bit is set");

    sleep_gate_a:
        assert property (sleep_mode && !s_q.sysen[FLASH_IF_SLEEP_CLOCK_ON]
                         |-> !sys_on[FLASH_IF_SLEEP_CLOCK_ON]
                         && (sys_on[SRAM_SLEEP_CLOCK_ON]
                             == s_q.sysen[SRAM_SLEEP_CLOCK_ON]))
        else $error("sleep clock enable not honoured");

    gate_enable_a:
        assert property ($fell(s_q.hsen[PORT_A_CLOCK_ON])
                         |-> !hs_on[PORT_A_CLOCK_ON]
                         && hs_on[1] == 1'b0 && sys_on[9] == 1'b0)
        else $error("clock enable does not follow register");

    dark_read_a:
        assert property (!all_on[periph_rd_sel]
                         |=> periph_rdata_out == 32'h0)
        else $error("clock-off peripheral returned data");
endmodule

// ===== tb/prcg_top_tb.sv
// self-checking bench for the reset and clock gate registers
`timescale 1ns/1ns
module prcg_top_tb;
    import prcg_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        sleep_mode, hsbus_busy;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, prd_in, prd_out;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [5:0]  prd_sel;
    logic [15:0] lf = 16'h0043;
    wire  [19:0] rst_v;
    wire  [21:0] clk_v;
    logic [31:0] m [3];
    logic [31:0] mk [3] = '{32'h3afec83f, 32'h00000557, 32'h0000fffd};
    logic [7:0]  ad [4] = '{8'h10, 8'h14, 8'h18, 8'h1c};
    logic [33:0] rq [$];
    logic [1:0]  bq [$];
    int          bad_count, total_checks, cyc;

    prcg_top DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .sleep_mode(sleep_mode), .hsbus_busy(hsbus_busy),
        .periph_rd_sel(prd_sel), .periph_rdata_in(prd_in),
        .periph_rdata_out(prd_out), .converter_if_rst_n(rst_v[19]),
        .power_if_rst_n(rst_v[18]), .backup_if_rst_n(rst_v[17]),
        .can_ctrl_rst_n(rst_v[16]), .usb_ctrl_rst_n(rst_v[15]),
        .second_i2c_rst_n(rst_v[14]), .first_i2c_rst_n(rst_v[13]),
        .serial5to2_rst_n(rst_v[12:9]), .third_spi_rst_n(rst_v[8]),
        .second_spi_rst_n(rst_v[7]), .window_watchdog_rst_n(rst_v[6]),
        .timer7to2_rst_n(rst_v[5:0]), .sd_host_clk(clk_v[21]),
        .static_mem_ctrl_clk(clk_v[20]), .checksum_unit_clk(clk_v[19]),
        .flash_if_clk(clk_v[18]), .sram_if_clk(clk_v[17]),
        .second_dma_clk(clk_v[16]), .first_dma_clk(clk_v[15]),
        .converter3_clk(clk_v[14]), .serial1_clk(clk_v[13]),
        .advanced_timer8_clk(clk_v[12]), .first_spi_clk(clk_v[11]),
        .advanced_timer1_clk(clk_v[10]), .converter2_clk(clk_v[9]),
        .converter1_clk(clk_v[8]), .port_g_to_a_clk(clk_v[7:1]),
        .alt_function_io_clk(clk_v[0]));

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    function automatic logic [15:0] nx(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic rnd(output logic [31:0] r);
        lf = nx(lf);
        r[15:0] = lf;
        lf = nx(lf);
        r[31:16] = lf;
    endtask

    function automatic int ix(input logic [7:0] a);
        return (a == 8'h10) ? 0 : (a == 8'h14) ? 1 : (a == 8'h18) ? 2 : 3;
    endfunction

    // bready and rready stay high, so no release race between calls
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        logic [31:0] bm;
        bit          ta, tw, tb;
        int          k;
        bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        k = ix(a);
        bq.push_back(k == 3 ? 2'h2 : 2'h0);
        if (k < 3) m[k] = (m[k] & ~bm) | (d & bm & mk[k]);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!tb);
    endtask

    task automatic rd(input logic [7:0] a, input bit lat);
        int n;
        bit t;
        n = ix(a);
        rq.push_back(n == 3 ? {2'h2, 32'h0} : {2'h0, m[n]});
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            t = arready;
            @(posedge aclk);
        end while (!t);
        arvalid <= 1'b0;
        n = 0;
        do begin
            @(negedge aclk);
            n++;
            t = rvalid;
            @(posedge aclk);
        end while (!t && n < 60);
        if (lat) chk(n, 2);
    endtask

    // gate enables settle half a cycle after the register, so wait first
    task automatic outs;
        logic sl;
        repeat (3) @(posedge aclk);
        #1;
        sl = sleep_mode;
        chk(rst_v, 20'(~{m[0][29:27], m[0][25], m[0][23:17], m[0][15:14],
            m[0][11], m[0][5:0]}));
        chk(clk_v, {m[1][10], m[1][8], m[1][6], !sl || m[1][4],
            !sl || m[1][2], m[1][1:0], m[2][15:2], m[2][0]});
        @(negedge aclk);
        #1;
        chk(clk_v, 22'h0);
        @(posedge aclk);
    endtask

    always @(negedge aclk) begin
        if (rvalid && rready)
            chk({rresp, rdata}, rq.pop_front());
        if (bvalid && bready)
            chk(bresp, bq.pop_front());
    end

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    initial begin
        logic [31:0] r;
        bit          en;
        {aresetn, awvalid, wvalid, arvalid, sleep_mode, hsbus_busy} = '0;
        {awaddr, araddr, wdata, wstrb, prd_sel, prd_in} = '0;
        bready = 1'b1;
        rready = 1'b1;
        m = '{32'h0, 32'h14, 32'h0};
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 3; i++) rd(ad[i], 1);
        outs();
        for (int i = 0; i < 4; i++) begin
            wr(ad[i], 32'hffffffff, 4'hf);
            rd(ad[i], 1);
        end
        outs();
        wr(ad[0], 32'h0, 4'h1);
        wr(ad[2], 32'h0, 4'hc);
        for (int i = 0; i < 3; i++) rd(ad[i], 1);
        for (int i = 0; i < 24; i++) begin
            rnd(r);
            sleep_mode <= r[6];
            wr(ad[r[1:0]], {r[15:0], r[31:16]}, r[5:2]);
            rd(ad[r[9:8]], 1);
            outs();
        end
        // a peripheral read must see zero while its clock is off
        for (int i = 0; i < 32; i++) begin
            rnd(r);
            prd_sel <= r[5:0];
            prd_in <= r;
            sleep_mode <= r[6];
            @(posedge aclk);
            @(negedge aclk);
            en = r[5] ? m[2][r[4:0]] :
                 ((r[4:0] == 5'd4 || r[4:0] == 5'd2) && !r[6]) ? 1'b1 :
                 m[1][r[4:0]];
            chk(prd_out, en ? r : 32'h0);
            @(posedge aclk);
        end
        hsbus_busy <= 1'b1;
        rd(ad[0], 1);
        // a read, then a write, of the high-speed register stall while busy
        for (int j = 0; j < 2; j++) begin
            if (j > 0) hsbus_busy <= 1'b1;
            fork
                if (j == 0) rd(ad[2], 0);
                else wr(ad[2], r, 4'h3);
                begin
                    repeat (6) begin
                        @(negedge aclk);
                        chk(j ? bvalid : rvalid, 1'b0);
                    end
                    @(posedge aclk);
                    hsbus_busy <= 1'b0;
                end
            join
        end
        rd(ad[2], 1);
        end_of_test();
    end
endmodule
